//--- sac_cmp_model.sv
// Behavioural comparator seen by the converter control block
`timescale 1ns/1ps
`default_nettype none
`include "sac_defs.svh"

module sac_cmp_model #(
	parameter logic [`SAC_CAL_W-1:0] CAL_TRIM = 8'h5A
) (
	input  wire logic                  calibrate,
	input  wire logic                  sample,
	input  wire logic                  current_monitor_strobe,
	input  wire logic                  postcal_strobe,
	input  wire logic [`SAC_RES_W-1:0] cap_switch,
	input  wire logic [`SAC_CAL_W-1:0] cal_code,
	input  wire logic [`SAC_RES_W-1:0] vin,
	output var  logic                  comparator
);
	logic [`SAC_RES_W-1:0] held;

	// Track and hold; a strobe dropped before sampling ends discharges it to zero
	always_latch begin
		if (sample) begin
			held <= current_monitor_strobe ? vin : '0;
		end
	end

	// Trim overshoot reads high, so calibration settles on CAL_TRIM
	always_comb begin
		if (calibrate || postcal_strobe) begin
			comparator = (cal_code > CAL_TRIM);
		end else begin
			comparator = (held >= cap_switch);
		end
	end
endmodule : sac_cmp_model

`default_nettype wire

//--- sac_conv_ctrl.sv
// Sequencer for calibration, sampling, approximation and result hand-off
`timescale 1ns/1ps
`default_nettype none
`include "sac_defs.svh"

module sac_conv_ctrl import sac_pkg::*; (
	input  wire logic                   clock,
	input  wire logic                   rst,
	input  wire logic                   converter_reset,
	input  wire logic                   conversion_start,
	input  wire logic [`SAC_CHAN_W-1:0] channel_select,
	input  wire logic [1:0]             resolution_select,
	input  wire logic [`SAC_ACQ_W-1:0]  sample_cycles,
	input  wire logic                   comparator,
	output var  logic                   calibrate,
	output var  logic                   sample,
	output var  logic                   busy,
	output var  logic                   result_valid,
	output var  logic [`SAC_RES_W-1:0]  result,
	output var  logic [`SAC_RES_W-1:0]  cap_switch,
	output var  logic [`SAC_CAL_W-1:0]  cal_code,
	output var  logic [`SAC_CHAN_W-1:0] channel_hold,
	output var  logic                   postcal_strobe,
	output var  logic [`SAC_PTR_W-1:0]  postcal_target
);

	sac_state_t             state;
	logic [`SAC_CNT_W-1:0]  cal_cnt;
	logic [`SAC_SLOT_W-1:0] slot_cnt;
	logic [2:0]             cal_bit;
	logic [`SAC_ACQ_W-1:0]  acq_cnt;
	logic [`SAC_PTR_W-1:0]  top_bit;

	sac_state_t             next_state;
	logic [`SAC_CNT_W-1:0]  next_cal_cnt;
	logic [`SAC_SLOT_W-1:0] next_slot_cnt;
	logic [2:0]             next_cal_bit;
	logic [`SAC_CAL_W-1:0]  next_cal_code;
	logic [`SAC_ACQ_W-1:0]  next_acq_cnt;
	logic [`SAC_PTR_W-1:0]  next_top_bit;
	logic [`SAC_CHAN_W-1:0] next_channel_hold;
	logic                   next_calibrate;
	logic                   next_sample;
	logic                   next_busy;
	logic                   next_result_valid;
	logic [`SAC_RES_W-1:0]  next_result;
	logic                   next_postcal_strobe;
	logic [`SAC_PTR_W-1:0]  next_postcal_target;
	logic                   sar_load;
	logic                   sar_step;

	sac_sar_if sar ();

	sac_sar_core u_core (
		.clock (clock),
		.rst   (rst),
		.sar   (sar)
	);

	assign sar.load    = sar_load;
	assign sar.step    = sar_step;
	assign sar.top_bit = top_bit;
	assign sar.comp    = comparator;
	assign cap_switch  = sar.caps;

	always_comb begin
		next_state          = state;
		next_cal_cnt        = cal_cnt;
		next_slot_cnt       = slot_cnt;
		next_cal_bit        = cal_bit;
		next_cal_code       = cal_code;
		next_acq_cnt        = acq_cnt;
		next_top_bit        = top_bit;
		next_channel_hold   = channel_hold;
		next_calibrate      = calibrate;
		next_sample         = sample;
		next_busy           = busy;
		next_result_valid   = result_valid;
		next_result         = result;
		next_postcal_strobe = 1'h0;
		next_postcal_target = postcal_target;
		sar_load            = 1'h0;
		sar_step            = 1'h0;
		if (converter_reset) begin
			// Calibration restarts from scratch; the last result is kept
			next_state          = SAC_CAL;
			next_cal_cnt        = '0;
			next_slot_cnt       = '0;
			next_cal_bit        = `SAC_CAL_BIT0;
			next_cal_code       = `SAC_CAL_START;
			next_calibrate      = 1'h1;
			next_sample         = 1'h0;
			next_busy           = 1'h0;
			next_result_valid   = 1'h0;
			next_postcal_target = '0;
		end else begin
			case (state)
				SAC_CAL: begin
					// Eight slots of equal length, one per calibration code bit
					next_cal_cnt = cal_cnt + 12'h001;
					if (slot_cnt == `SAC_CAL_SLOT - 9'h001) begin
						next_slot_cnt = '0;
						next_cal_code[cal_bit] = ~comparator;
						if (cal_bit != 3'h0) begin
							next_cal_code[3'(cal_bit - 3'h1)] = 1'h1;
							next_cal_bit = 3'(cal_bit - 3'h1);
						end
					end else begin
						next_slot_cnt = slot_cnt + 9'h001;
					end
					if (cal_cnt == `SAC_CAL_CYCLES - 12'h001) begin
						next_state     = SAC_IDLE;
						next_calibrate = 1'h0;
					end
				end
				SAC_IDLE: begin
					// Only idle takes a start, so calibration and busy drop it
					if (conversion_start) begin
						next_state        = SAC_SAMPLE;
						next_sample       = 1'h1;
						next_busy         = 1'h1;
						next_result_valid = 1'h0;
						next_channel_hold = channel_select;
						next_acq_cnt      = (sample_cycles == 8'h00) ? `SAC_ACQ_MIN :
							sample_cycles;
						case (resolution_select)
							SAC_RES8:  next_top_bit = `SAC_TOP_8;
							SAC_RES10: next_top_bit = `SAC_TOP_10;
							default:   next_top_bit = `SAC_TOP_12;
						endcase
					end
				end
				SAC_SAMPLE: begin
					if (acq_cnt == `SAC_ACQ_MIN) begin
						// Hold reached: MSB capacitor goes to the reference
						sar_load    = 1'h1;
						next_sample = 1'h0;
						next_state  = SAC_CONVERT;
					end else begin
						next_acq_cnt = acq_cnt - 8'h01;
					end
				end
				SAC_CONVERT: begin
					sar_step = 1'h1;
					if (sar.ptr == 4'h0) begin
						next_state          = SAC_POST;
						next_postcal_strobe = 1'h1;
					end
				end
				SAC_POST: begin
					// The extra cycle recalibrates one element while the result settles
					next_result       = sar.caps;
					next_busy         = 1'h0;
					next_result_valid = 1'h1;
					next_state        = SAC_IDLE;
					if (comparator) begin
						if (cal_code != `SAC_CAL_MIN) begin
							next_cal_code = cal_code - 8'h01;
						end
					end else if (cal_code != `SAC_CAL_MAX) begin
						next_cal_code = cal_code + 8'h01;
					end
					if (postcal_target >= top_bit + 4'h1) begin
						next_postcal_target = '0;
					end else begin
						next_postcal_target = postcal_target + 4'h1;
					end
				end
				default: begin
					next_state = SAC_CAL;
				end
			endcase
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state          <= SAC_CAL;
			cal_cnt        <= '0;
			slot_cnt       <= '0;
			cal_bit        <= `SAC_CAL_BIT0;
			cal_code       <= `SAC_CAL_START;
			acq_cnt        <= `SAC_ACQ_MIN;
			top_bit        <= `SAC_TOP_12;
			channel_hold   <= '0;
			calibrate      <= 1'h1;
			sample         <= 1'h0;
			busy           <= 1'h0;
			result_valid   <= 1'h0;
			result         <= '0;
			postcal_strobe <= 1'h0;
			postcal_target <= '0;
		end else begin
			state          <= next_state;
			cal_cnt        <= next_cal_cnt;
			slot_cnt       <= next_slot_cnt;
			cal_bit        <= next_cal_bit;
			cal_code       <= next_cal_code;
			acq_cnt        <= next_acq_cnt;
			top_bit        <= next_top_bit;
			channel_hold   <= next_channel_hold;
			calibrate      <= next_calibrate;
			sample         <= next_sample;
			busy           <= next_busy;
			result_valid   <= next_result_valid;
			result         <= next_result;
			postcal_strobe <= next_postcal_strobe;
			postcal_target <= next_postcal_target;
		end
	end

	// Helper counters that only the checks read
	logic [`SAC_LEN_W-1:0] busy_len;
	logic [`SAC_ACQ_W-1:0] acq_len;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			busy_len <= '0;
			acq_len  <= `SAC_ACQ_MIN;
		end else begin
			busy_len <= busy ? busy_len + 9'h001 : 9'h000;
			if (state == SAC_IDLE && conversion_start && !converter_reset) begin
				acq_len <= (sample_cycles == 8'h00) ? `SAC_ACQ_MIN : sample_cycles;
			end
		end
	end

	chk_cal_stays_high: assert property (@(posedge clock) disable iff (rst)
		calibrate && !converter_reset && cal_cnt != `SAC_CAL_CYCLES - 12'h001
		|=> calibrate)
		else $error("calibration ended early");

	chk_cal_full_length: assert property (@(posedge clock) disable iff (rst)
		$fell(calibrate) |-> $past(cal_cnt) == `SAC_CAL_CYCLES - 12'h001)
		else $error("calibration length wrong");

	chk_start_accepted: assert property (@(posedge clock) disable iff (rst)
		conversion_start && !busy && !calibrate && !converter_reset
		|=> sample && busy && !result_valid && channel_hold == $past(channel_select))
		else $error("start not taken correctly");

	chk_start_ignored: assert property (@(posedge clock) disable iff (rst)
		conversion_start && (busy || calibrate) && !converter_reset
		|=> !$rose(sample) && $stable(channel_hold))
		else $error("start taken while busy or calibrating");

	chk_sample_then_busy: assert property (@(posedge clock) disable iff (rst)
		$fell(sample) && !$past(converter_reset) |-> busy ##1 busy)
		else $error("busy not held after sampling");

	chk_conv_duration: assert property (@(posedge clock) disable iff (rst)
		$fell(busy) && !$past(converter_reset)
		|-> busy_len == 9'(acq_len) + 9'(top_bit) + 9'h002)
		else $error("conversion length wrong");

	chk_done_flags: assert property (@(posedge clock) disable iff (rst)
		$fell(busy) && !$past(converter_reset)
		|-> result_valid && result == $past(cap_switch))
		else $error("completion flags or result wrong");

	chk_valid_holds: assert property (@(posedge clock) disable iff (rst)
		result_valid && !conversion_start && !converter_reset |=> result_valid)
		else $error("result valid dropped without start");

	chk_result_latched: assert property (@(posedge clock) disable iff (rst)
		$changed(result) |-> $rose(result_valid))
		else $error("result changed outside completion");

	chk_postcal_advance: assert property (@(posedge clock) disable iff (rst)
		postcal_strobe && !converter_reset
		|=> !postcal_strobe && postcal_target != $past(postcal_target) && result_valid)
		else $error("post-calibration step did not advance");

endmodule : sac_conv_ctrl

`default_nettype wire

//--- sac_defs.svh
// Widths, reset values and cycle counts of the converter control block
`ifndef SAC_DEFS_SVH
`define SAC_DEFS_SVH

`define SAC_RES_W      12
`define SAC_CAL_W      8
`define SAC_CHAN_W     5
`define SAC_PTR_W      4
`define SAC_ACQ_W      8
`define SAC_CNT_W      12
`define SAC_SLOT_W     9
`define SAC_LEN_W      9

`define SAC_CAL_CYCLES 12'hF00
`define SAC_CAL_SLOT   9'h1E0
`define SAC_CAL_START  8'h80
`define SAC_CAL_BIT0   3'h7
`define SAC_CAL_MIN    8'h00
`define SAC_CAL_MAX    8'hFF

`define SAC_TOP_8      4'h7
`define SAC_TOP_10     4'h9
`define SAC_TOP_12     4'hB

`define SAC_ACQ_MIN    8'h01

`endif

//--- sac_pkg.sv
// Types shared by the converter control modules
package sac_pkg;

	typedef enum logic [2:0] {
		SAC_CAL     = 3'b000,
		SAC_IDLE    = 3'b001,
		SAC_SAMPLE  = 3'b010,
		SAC_CONVERT = 3'b011,
		SAC_POST    = 3'b100
	} sac_state_t;

	typedef enum logic [1:0] {
		SAC_RES8  = 2'b00,
		SAC_RES10 = 2'b01,
		SAC_RES12 = 2'b10
	} sac_mode_t;

endpackage : sac_pkg

//--- sac_sar_core.sv
// Successive approximation register driving the main capacitor array
`timescale 1ns/1ps
`default_nettype none
`include "sac_defs.svh"

module sac_sar_core import sac_pkg::*; (
	input wire logic clock,
	input wire logic rst,
	sac_sar_if.core  sar
);

	logic [`SAC_RES_W-1:0] caps;
	logic [`SAC_PTR_W-1:0] ptr;
	logic [`SAC_RES_W-1:0] next_caps;
	logic [`SAC_PTR_W-1:0] next_ptr;
	logic [`SAC_PTR_W-1:0] ptr_down;

	assign ptr_down = ptr - 4'h1;

	// Bits above the pointer hold decisions, the pointer bit is the trial
	generate
		for (genvar i = 0; i < `SAC_RES_W; i++) begin : g_bit
			assign next_caps[i] = sar.load ? (sar.top_bit == 4'(i)) :
				(sar.step && ptr == 4'(i)) ? sar.comp :
				(sar.step && ptr != 4'h0 && ptr_down == 4'(i)) ? 1'h1 :
				caps[i];
		end
	endgenerate

	always_comb begin
		next_ptr = ptr;
		if (sar.load) begin
			next_ptr = sar.top_bit;
		end else if (sar.step && ptr != 4'h0) begin
			next_ptr = ptr_down;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			caps <= '0;
			ptr  <= '0;
		end else begin
			caps <= next_caps;
			ptr  <= next_ptr;
		end
	end

	assign sar.caps = caps;
	assign sar.ptr  = ptr;

	chk_msb_trial_first: assert property (@(posedge clock) disable iff (rst)
		sar.load |=> caps == (12'h001 << $past(sar.top_bit)))
		else $error("largest capacitor not placed on reference first");

	chk_bit_decision_kept: assert property (@(posedge clock) disable iff (rst)
		sar.step && !sar.load && ptr != 4'h0 |=>
		caps[$past(ptr)] == $past(sar.comp) && caps[$past(ptr) - 4'h1])
		else $error("decision or next trial capacitor wrong");

endmodule : sac_sar_core

`default_nettype wire

//--- sac_sar_if.sv
// Control and result signals between the sequencer and the approximation register
`timescale 1ns/1ps
`default_nettype none
`include "sac_defs.svh"

interface sac_sar_if;
	logic                  load;
	logic                  step;
	logic [`SAC_PTR_W-1:0] top_bit;
	logic                  comp;
	logic [`SAC_RES_W-1:0] caps;
	logic [`SAC_PTR_W-1:0] ptr;

	modport ctrl (output load, output step, output top_bit, output comp,
		input caps, input ptr);
	modport core (input load, input step, input top_bit, input comp,
		output caps, output ptr);
endinterface : sac_sar_if

`default_nettype wire

//--- sac_tb.sv
// Self-checking testbench of the converter control block
`timescale 1ns/1ps
`default_nettype none
`include "sac_defs.svh"

module testbench import sac_pkg::*;;
	localparam logic [7:0] CAL_TRIM = 8'h5A;
	localparam int         VREF_MV     = 2560;
	localparam int         RSENSE_MOHM = 50;
	localparam int         CUR_MA      = 1000;
	logic        clock;
	logic        rst;
	logic        converter_reset;
	logic        conversion_start;
	logic [4:0]  channel_select;
	logic [1:0]  resolution_select;
	logic [7:0]  sample_cycles;
	logic        comparator;
	logic        calibrate;
	logic        sample;
	logic        busy;
	logic        result_valid;
	logic [11:0] result;
	logic [11:0] cap_switch;
	logic [7:0]  cal_code;
	logic [4:0]  channel_hold;
	logic        postcal_strobe;
	logic [3:0]  postcal_target;
	logic [11:0] vin;
	logic [3:0]  tgt;
	logic [7:0]  cal_exp;
	logic        current_monitor_strobe;
	int          n_errors = 0;
	int          num_checks = 0;

	sac_conv_ctrl sac_conv_ctrl_inst (.clock(clock), .rst(rst), .converter_reset(converter_reset),
		.conversion_start(conversion_start), .channel_select(channel_select),
		.resolution_select(resolution_select), .sample_cycles(sample_cycles),
		.comparator(comparator), .calibrate(calibrate), .sample(sample), .busy(busy),
		.result_valid(result_valid), .result(result), .cap_switch(cap_switch),
		.cal_code(cal_code), .channel_hold(channel_hold), .postcal_strobe(postcal_strobe),
		.postcal_target(postcal_target));

	sac_cmp_model #(.CAL_TRIM(CAL_TRIM)) sac_cmp_model_inst (.calibrate(calibrate),
		.postcal_strobe(postcal_strobe), .cap_switch(cap_switch), .cal_code(cal_code),
		.vin(vin), .sample(sample), .current_monitor_strobe(current_monitor_strobe),
		.comparator(comparator));

	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end

	task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
		num_checks++;
		if (exp !== got) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic final_report();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : final_report

	// Current in mA from a current-monitor code; reference in mV, sense in milliohm
	function automatic int to_ma(input logic [11:0] code, input int nbits);
		return int'((longint'(code) * VREF_MV * 1000) /
			(10 * (longint'(1) << nbits) * RSENSE_MOHM));
	endfunction : to_ma

	// Entered at the falling edge where the reset was last seen
	task automatic cal_wait();
		int n;
		n = 0;
		while (calibrate === 1'b1 && n < 5000) begin
			n++;
			conversion_start = (n == 100);
			if (n == 103) chk("busy_in_cal", 12'h000, 12'(busy));
			@(negedge clock);
		end
		chk("cal_len", 12'hF00, 12'(n));
		chk("cal_code", 12'(CAL_TRIM), 12'(cal_code));
		cal_exp = CAL_TRIM;
	endtask : cal_wait

	task automatic convert(input logic [1:0] mode, input logic [7:0] acq,
		input logic [11:0] v, input logic [4:0] ch);
		int nb, ns, np, nn;
		logic [11:0] prev;
		nn = (mode == 2'h0) ? 8 : (mode == 2'h1) ? 10 : 12;
		prev = result;
		vin = v;
		resolution_select = mode;
		sample_cycles = acq;
		channel_select = ch;
		current_monitor_strobe = 1'b0;
		@(negedge clock);
		current_monitor_strobe = 1'b1;
		@(negedge clock);
		conversion_start = 1'b1;
		@(negedge clock);
		conversion_start = 1'b0;
		chk("accept", 12'h006, {9'h000, sample, busy, result_valid});
		nb = 0;
		ns = 0;
		np = 0;
		while (busy === 1'b1 && nb < 100) begin
			nb++;
			if (sample === 1'b1) ns++;
			if (nb == ns + 1) chk("msb_trial", 12'(12'h001 << (nn - 1)), cap_switch);
			if (postcal_strobe === 1'b1) begin
				np++;
				chk("postcal_target", 12'(tgt), 12'(postcal_target));
				tgt = (tgt >= nn) ? 4'h0 : tgt + 4'h1;
				cal_exp = (cal_exp > CAL_TRIM) ? cal_exp - 8'h01 : cal_exp + 8'h01;
			end
			chk("result_hold", prev, result);
			// A start while busy must leave the timing untouched
			conversion_start = (nb == 4);
			@(negedge clock);
		end
		chk("sample_len", 12'((acq == 8'h00) ? 1 : acq), 12'(ns));
		chk("busy_len", 12'(((acq == 8'h00) ? 1 : acq) + nn + 1), 12'(nb));
		chk("postcal_count", 12'h001, 12'(np));
		chk("postcal_code", 12'(cal_exp), 12'(cal_code));
		chk("done_valid", 12'h001, 12'(result_valid));
		chk("result", v, result);
		chk("channel", 12'(ch), 12'(channel_hold));
	endtask : convert

	initial begin
		logic [1:0]  m [6];
		logic [7:0]  a [6];
		logic [11:0] v [6];
		logic [4:0]  c [6];
		m = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h3, 2'h0};
		a = '{8'h02, 8'h00, 8'h05, 8'h01, 8'h03, 8'h01};
		v = '{12'h0A7, 12'h2C5, 12'hFFF, 12'h000, 12'h9A4, 12'h001};
		c = '{5'h03, 5'h1F, 5'h11, 5'h00, 5'h08, 5'h15};
		rst = 1'b1;
		converter_reset = 1'b0;
		conversion_start = 1'b0;
		channel_select = 5'h00;
		resolution_select = 2'h0;
		sample_cycles = 8'h01;
		vin = 12'h000;
		tgt = 4'h0;
		cal_exp = CAL_TRIM;
		current_monitor_strobe = 1'b1;
		repeat (10) @(negedge clock);
		chk("reset_cal", 12'h180, {3'h0, calibrate, cal_code});
		rst = 1'b0;
		cal_wait();
		convert(2'h0, 8'h03, 12'((CUR_MA * 10 * 256 * RSENSE_MOHM) / (VREF_MV * 1000)), 5'h1E);
		chk("current_ma", 12'(CUR_MA), 12'(to_ma(result, 8)));
		for (int i = 0; i < 6; i++) begin
			convert(m[i], a[i], v[i], c[i]);
		end
		repeat (5) @(negedge clock);
		chk("valid_kept", 12'h001, 12'(result_valid));
		converter_reset = 1'b1;
		@(negedge clock);
		converter_reset = 1'b0;
		chk("conv_reset", 12'h004, {9'h000, calibrate, busy, result_valid});
		chk("result_kept", 12'h001, result);
		tgt = 4'h0;
		cal_wait();
		convert(2'h1, 8'h04, 12'h3FF, 5'h0A);
		final_report();
	end

	// Two calibrations and a few conversions need about 8000 cycles
	initial begin
		repeat (20000) @(posedge clock);
		n_errors++;
		final_report();
	end
endmodule : testbench

`default_nettype wire
